// [verilog/dpsr_cfg.svh]
// register offsets, field positions and codes of the pll status readback block
`ifndef DPSR_CFG_SVH
`define DPSR_CFG_SVH
`define DPSR_OFS_STICKY 16'h0200
`define DPSR_OFS_ENABLE 16'h0079
`define DPSR_OFS_REF 16'h0202
`define DPSR_OFS_STATE 16'h0203
`define DPSR_OFS_GPI 16'h020C
`define DPSR_OFS_ALERT 16'h020D
`define DPSR_OFS_LDERR 16'h0210
`define DPSR_OFS_LDDONE 16'h0211
`define DPSR_BIT_NOREF 3
`define DPSR_BIT_LOCK 4
`define DPSR_ALERT_MASK 8'h2B
`define DPSR_REF_IN0 3'h4
`define DPSR_REF_IN1 3'h5
`define DPSR_STATE_FREERUN 2'h1
`define DPSR_STATE_NORMAL 2'h2
`define DPSR_STATE_HOLDOVER 2'h3
`define DPSR_ZERO8 8'h00
`endif

// [verilog/dpsr_pkg.sv]
// types shared by the pll status readback block
package dpsr_pkg;
    typedef struct packed {
        logic no_valid_reference;
        logic [2:0] selected_reference;
        logic phase_lock_raw;
        logic synth_mode;
        logic [1:0] pll_state;
    } dpsr_pll_s;
    typedef struct packed {
        logic crc_mismatch;
        logic read_failed;
        logic read_done;
    } dpsr_boot_s;
endpackage

// [verilog/dpsr_status.sv]
// pll status, general input, alert summary and boot result readback
// Contract
// R1: no-valid-reference flag is 1 exactly when no input reference is valid.
// R2: three-bit selected reference: 100 input 0, 101 input 1, else none.
// R3: phase lock shown while error below criterion, never in synthesizer mode.
// R4: pll state 01 freerun, 10 normal, 11 holdover; 00 never produced.
// R5: pll fields come live from the pll, with no latching.
// R6: pll status is debug only; values read are momentary.
// R7: host uses sticky alerts and pins, not polling, for fast changes.
// R8: general input byte returns levels of pins configured as inputs.
// R9: alert summary is 1 when any enabled sticky alert bit is set.
// R10: alert pin driven low while summary is 1, released otherwise.
// R11: crc mismatch flag sets on failed crc, held until reset.
// R12: load failed flag sets on eeprom read failure, held until reset.
// R13: load done flag sets when eeprom read completes, held until reset.
// R14: host writes zero to reserved bits and ignores their read value.
// R15: sticky alert bits hold until host writes one to them.
// R16: a sticky bit counts toward the alert only while enabled.
// R17: alert summary is the continuous or of sticky and enable.
`include "dpsr_cfg.svh"
module dpsr_status (
    input wire logic clk_i, // 40 MHz core clock
    input wire logic reset_i, // synchronous, active high
    input wire dpsr_pkg::dpsr_pll_s pll_i, // live pll state
    input wire logic [3:0] gpio_level_i, // gpio pin levels
    input wire logic [3:0] gpio_is_input_i, // 1 where pin is an input
    input wire logic [7:0] alarm_event_i, // alarm pulses, sticky bit lanes
    input wire dpsr_pkg::dpsr_boot_s boot_event_i, // loader result pulses
    input wire logic [15:0] addr_i, // register address
    input wire logic wr_i, // write strobe
    input wire logic [7:0] wdata_i, // write data
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, registered
    output logic rvalid_o, // read data valid pulse
    output logic [7:0] alert_sticky_o, // sticky alert bits
    output logic alert_summary_o, // device alert summary
    output logic alert_pin_n_o, // active-low alert pin level
    output logic alert_pin_n_oe_o // alert pin drive enable, open drain
);
    logic [7:0] sticky_reg, sticky_next;
    logic [7:0] enable_reg, enable_next;
    logic crc_mismatch_reg, load_failed_reg, load_done_reg;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg;
    logic [2:0] sel_ref;
    logic [1:0] state_code;
    logic phase_lock_flag;
    logic [7:0] ref_byte, state_byte, gpi_byte, alert_byte, err_byte, done_byte;
    logic wr_sticky, wr_enable;
    // R2 reserved codes 110/111 are folded to none-selected
    assign sel_ref = (pll_i.selected_reference == `DPSR_REF_IN0 ||
                      pll_i.selected_reference == `DPSR_REF_IN1) ? pll_i.selected_reference : 3'h0;
    // R4 never present 00; an unknown code reads as freerun
    assign state_code = (pll_i.pll_state == 2'h0) ? `DPSR_STATE_FREERUN : pll_i.pll_state;
    // R3 gate lock off in synthesizer mode
    assign phase_lock_flag = pll_i.phase_lock_raw & ~pll_i.synth_mode;
    // R5 R6 live fields, no snapshot, R1 no-reference bit
    // a read may mix fields from two pll states; only the sticky bits catch fast changes
    assign ref_byte = {4'h0, pll_i.no_valid_reference, sel_ref};
    assign state_byte = {3'h0, phase_lock_flag, 2'h0, state_code};
    // R8 only input-configured pins show
    assign gpi_byte = {4'h0, gpio_level_i & gpio_is_input_i};
    // R17 R16 R9 continuous enabled or
    assign alert_summary_o = |(sticky_reg & enable_reg);
    assign alert_byte = {7'h00, alert_summary_o};
    assign err_byte = {6'h00, crc_mismatch_reg, load_failed_reg};
    assign done_byte = {7'h00, load_done_reg};
    // R10 open drain: drive low only while summary is set
    assign alert_pin_n_o = 1'b0;
    assign alert_pin_n_oe_o = alert_summary_o;
    assign alert_sticky_o = sticky_reg;
    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign wr_sticky = wr_i && addr_i == `DPSR_OFS_STICKY;
    assign wr_enable = wr_i && addr_i == `DPSR_OFS_ENABLE;
    // R15 write-one-to-clear; a new event wins over the clear; R14 reserved lanes masked
    assign sticky_next = ((sticky_reg & ~(wr_sticky ? wdata_i : `DPSR_ZERO8)) | alarm_event_i)
                         & `DPSR_ALERT_MASK;
    assign enable_next = wr_enable ? (wdata_i & `DPSR_ALERT_MASK) : enable_reg;
    always_comb begin
        unique case (addr_i)
            `DPSR_OFS_STICKY: rdata_next = sticky_reg;
            `DPSR_OFS_ENABLE: rdata_next = enable_reg;
            `DPSR_OFS_REF: rdata_next = ref_byte;
            `DPSR_OFS_STATE: rdata_next = state_byte;
            `DPSR_OFS_GPI: rdata_next = gpi_byte;
            `DPSR_OFS_ALERT: rdata_next = alert_byte;
            `DPSR_OFS_LDERR: rdata_next = err_byte;
            `DPSR_OFS_LDDONE: rdata_next = done_byte;
            default: rdata_next = `DPSR_ZERO8;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sticky_reg <= `DPSR_ZERO8;
            enable_reg <= `DPSR_ZERO8;
            rdata_reg <= `DPSR_ZERO8;
            rvalid_reg <= 1'b0;
        end else begin
            sticky_reg <= sticky_next;
            enable_reg <= enable_next;
            rdata_reg <= rd_i ? rdata_next : rdata_reg;
            rvalid_reg <= rd_i;
        end
    end
    // R11 R12 R13 boot flags set once, cleared only by reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            crc_mismatch_reg <= 1'b0;
            load_failed_reg <= 1'b0;
            load_done_reg <= 1'b0;
        end else begin
            crc_mismatch_reg <= crc_mismatch_reg | boot_event_i.crc_mismatch;
            load_failed_reg <= load_failed_reg | boot_event_i.read_failed;
            load_done_reg <= load_done_reg | boot_event_i.read_done;
        end
    end
endmodule

// [sim/dpsr_status_chk.sv]
// port assertions for the pll status readback block
module dpsr_status_chk (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire dpsr_pkg::dpsr_pll_s pll_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [7:0] alert_sticky_o,
    input wire logic alert_summary_o,
    input wire logic alert_pin_n_o,
    input wire logic alert_pin_n_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    a_rv: assert property (rd_i |=> rvalid_o)
        else $error("read answer missing");
    a_nrv: assert property (!rd_i |=> !rvalid_o)
        else $error("stray read valid");
    a_ref: assert property (rd_i && addr_i == 16'h0202 |=> rdata_o[7:3] == {4'h0, $past(pll_i.no_valid_reference)})
        else $error("reference flag wrong");
    a_lck: assert property (rd_i && addr_i == 16'h0203 |=> rdata_o[4] == $past(pll_i.phase_lock_raw & ~pll_i.synth_mode))
        else $error("lock flag wrong");
    a_st: assert property (rd_i && addr_i == 16'h0203 |=> rdata_o[1:0] != 2'h0)
        else $error("reserved pll state");
    a_pin: assert property (alert_pin_n_oe_o == alert_summary_o && !alert_pin_n_o)
        else $error("alert pin wrong");
    a_sum: assert property (alert_summary_o |-> alert_sticky_o != 8'h00)
        else $error("summary without sticky");
    a_hold: assert property (alert_sticky_o[5] && !(wr_i && addr_i == 16'h0200 && wdata_i[5]) |=> alert_sticky_o[5])
        else $error("sticky bit lost");
endmodule

// [sim/dpsr_host.sv]
// host model issuing register reads and writes
`include "dpsr_cfg.svh"
module dpsr_host (
    input wire logic clk_i, // core clock
    input wire logic [7:0] rdata_i, // read data
    input wire logic rvalid_i, // read valid
    output logic [15:0] addr_o = 16'h0000, // address
    output logic wr_o = 1'b0, // write strobe
    output logic [7:0] wdata_o = 8'h00, // write data
    output logic rd_o = 1'b0 // read strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o} = {a, d & `DPSR_ALERT_MASK, 1'b1};
        @(negedge clk_i);
        wr_o = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        int n;
        @(negedge clk_i);
        {addr_o, rd_o} = {a, 1'b1};
        @(negedge clk_i);
        rd_o = 1'b0;
        for (n = 0; n < 4 && rvalid_i !== 1'b1; n++) @(negedge clk_i);
        d = rdata_i;
        if (n == 4) begin
            tb_dpsr_status.err_total++;
            tb_dpsr_status.stop_test();
        end
    endtask
endmodule

// [sim/tb_dpsr_status.sv]
// testbench for the pll status readback block
module tb_dpsr_status;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0, reset_i = 1'b1, wr_i, rd_i, rvalid_o, alert_summary_o, alert_pin_n_o, alert_pin_n_oe_o;
    dpsr_pkg::dpsr_pll_s pll_i = 8'h00;
    dpsr_pkg::dpsr_boot_s boot_event_i = 3'h0;
    logic [3:0] gpio_level_i = 4'hA, gpio_is_input_i = 4'h6;
    logic [7:0] alarm_event_i = 8'h00, wdata_i, rdata_o, alert_sticky_o, d;
    logic [15:0] addr_i;
    int err_total = 0, check_count = 0;
    dpsr_status dut_u (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pll_i(pll_i),
        .gpio_level_i(gpio_level_i),
        .gpio_is_input_i(gpio_is_input_i),
        .alarm_event_i(alarm_event_i),
        .boot_event_i(boot_event_i),
        .addr_i(addr_i),
        .wr_i(wr_i),
        .wdata_i(wdata_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .rvalid_o(rvalid_o),
        .alert_sticky_o(alert_sticky_o),
        .alert_summary_o(alert_summary_o),
        .alert_pin_n_o(alert_pin_n_o),
        .alert_pin_n_oe_o(alert_pin_n_oe_o)
    );
    dpsr_host host_u (.clk_i, .rdata_i(rdata_o), .rvalid_i(rvalid_o), .addr_o(addr_i), .wr_o(wr_i),
        .wdata_o(wdata_i), .rd_o(rd_i));
    initial forever #12.5 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        host_u.rd(a, d);
        chk(d, e);
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic pulse(input logic [7:0] al, input logic [2:0] bt);
        @(negedge clk_i);
        {alarm_event_i, boot_event_i} = {al, bt};
        @(negedge clk_i);
        {alarm_event_i, boot_event_i} = 11'h000;
    endtask
    initial begin
        repeat (8) @(negedge clk_i);
        reset_i = 1'b0;
        rc(16'h0079, 8'h00);
        rc(16'h0204, 8'h00);
        // live fields, every code
        for (int i = 0; i < 8; i++) begin
            pll_i = {i[0], i[2:0], 1'b1, i[1], i[1:0]};
            rc(16'h0202, {4'h0, i[0], (i == 4 || i == 5) ? i[2:0] : 3'h0});
            rc(16'h0203, {3'h0, ~i[1], 2'h0, (i[1:0] == 2'h0) ? 2'h1 : i[1:0]});
        end
        rc(16'h020C, 8'h02);
        pulse(8'h20, 3'h0);
        rc(16'h020D, 8'h00);
        chk(alert_sticky_o, 8'h20);
        host_u.wr(16'h0079, 8'hFF);
        rc(16'h020D, 8'h01);
        chk({6'h00, alert_pin_n_oe_o, alert_pin_n_o}, 8'h02);
        host_u.wr(16'h0200, 8'h20);
        rc(16'h020D, 8'h00);
        pulse(8'h00, 3'h7);
        host_u.wr(16'h0210, 8'h00);
        rc(16'h0210, 8'h03);
        rc(16'h0211, 8'h01);
        // mid-run reset must clear the boot flags; all pins now inputs
        @(negedge clk_i);
        reset_i = 1'b1;
        gpio_is_input_i = 4'hF;
        @(negedge clk_i);
        reset_i = 1'b0;
        rc(16'h0210, 8'h00);
        rc(16'h0211, 8'h00);
        rc(16'h020C, 8'h0A);
        stop_test();
    end
endmodule
bind dpsr_status dpsr_status_chk chk_u (.*);
